/* File: src/gpm_pkg.sv */
// constants shared by the general purpose pin block
package gpm_pkg;
	// pin counts
	localparam int NUM_PINS = 54;
	localparam int NUM_PART = 4;
	localparam int HP_GROUPS = 5;
	localparam int HP_GRP_PINS = 9;
	localparam int NUM_LPORT = 16;
	// fixed alternate pin positions
	localparam int PIN_GPE = 5;
	localparam int PIN_EXPINT = 8;
	localparam int PIN_HP_BASE = 9;
	localparam int PIN_LINK0_UP = 4;
	localparam int PIN_LINK0_ACT = 5;
	localparam int PIN_LINK_BASE = 22;
	localparam int PIN_LINK_LAST = 51;
	localparam int LINK_PORT_OFS = 20;
	// signal order inside one hot-plug group
	localparam int HP_AP = 0;
	localparam int HP_PD = 1;
	localparam int HP_PF = 2;
	localparam int HP_PG = 3;
	localparam int HP_MRL = 4;
	localparam int HP_AI = 5;
	localparam int HP_PI = 6;
	localparam int HP_PE = 7;
	localparam int HP_RS = 8;
	localparam int HP_NUM_IN = 5;
	// input sample interval, least time, rounded up
	localparam int CLK_PERIOD_NS = 8;
	localparam int SAMPLE_NS = 128;
	localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// register byte offsets; each pair is low word then high word
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_FUNC = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam logic [7:0] REG_AFSEL = 8'h18;
	localparam logic [7:0] REG_PAIR_MASK = 8'hF8;
	// reset values: every pin a general purpose input
	localparam logic [53:0] FUNC_RST = 54'h0;
	localparam logic [53:0] CFG_RST = 54'h0;
	localparam logic [53:0] DATA_RST = 54'h0;
	localparam logic [53:0] AFSEL_RST = 54'h0;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpm_pkg

/* File: src/gpm_sync.sv */
// two-stage pin synchroniser with a slow sample register
`timescale 1ns/1ps
module gpm_sync import gpm_pkg::*; #(
	parameter int W = NUM_PINS,
	parameter int CYC = SAMPLE_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// raw pins and sampled levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	localparam int CW = $clog2(CYC);
	localparam logic [CW-1:0] CNT_LAST = CW'(CYC - 1);

	// all state of the sampler
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] smp;
		logic [CW-1:0] cnt;
		logic en;
	} gpm_sync_st_t;

	gpm_sync_st_t st_r, st_nxt;

	// divider makes a one-cycle enable per interval
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.en = (st_r.cnt == CNT_LAST);
		st_nxt.cnt = st_nxt.en ? '0 : st_r.cnt + 1'b1;
		if (st_r.en) begin
			st_nxt.smp = st_r.s2;
		end
	end

	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.smp;

	// fifteen quiet cycles after each enable keep samples 128 ns apart
	AST_SAMPLE_GAP: assert property (@(posedge aclk)
		disable iff (!aresetn)
		st_r.en |=> (!st_r.en) [*8] ##1 (!st_r.en) [*7])
		else $error("sample enable came too soon");
	AST_SAMPLE_ONLY_EN: assert property (@(posedge aclk)
		disable iff (!aresetn)
		$changed(st_r.smp) |-> $past(st_r.en))
		else $error("sample changed outside an enable");
	COV_SAMPLE: cover property (@(posedge aclk) disable iff (!aresetn)
		$changed(st_r.smp));
endmodule : gpm_sync

/* File: src/gpm_port.sv */
// general purpose pin block with alternate functions and register slave
// Behaviour
// - 54 pins, each input, output or alternate
// - reset makes every pin an input
// - inputs double synchronised, sampled every 128 ns
// - function and direction bits decode pin mode
// - input mode pin level goes to data
// - data read returns sampled level always
// - output mode drives data latch bit
// - alternate select picks alternate 0 or 1
// - alternate pin direction follows selected signal
// - unmapped alternate inputs held inactive
// - partition reset pins 0-3 start partition reset
// - hot-plug inputs and outputs by signal type
// - link status outputs active low, all alternate 1
// - event out pin 5, expander interrupt pin 8
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module gpm_port import gpm_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	// register bus write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// register bus write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// register bus read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	// register bus read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// pins
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe_n,
	// alternate inputs passed to the core
	output logic [NUM_PART-1:0] partition_reset_n,
	output logic expander_interrupt_n,
	output logic [HP_GROUPS-1:0] hp_attention_button_n,
	output logic [HP_GROUPS-1:0] hp_presence_detect_n,
	output logic [HP_GROUPS-1:0] hp_power_fault_n,
	output logic [HP_GROUPS-1:0] hp_power_good_n,
	output logic [HP_GROUPS-1:0] hp_retention_latch_n,
	// alternate outputs coming from the core
	input wire logic hotplug_event_out,
	input wire logic [HP_GROUPS-1:0] hp_attention_indicator_n,
	input wire logic [HP_GROUPS-1:0] hp_power_indicator_n,
	input wire logic [HP_GROUPS-1:0] hp_power_enable,
	input wire logic [HP_GROUPS-1:0] hp_slot_reset_n,
	input wire logic [NUM_LPORT-1:0] port_link_up_n,
	input wire logic [NUM_LPORT-1:0] port_link_active_n
);
	// all state of the block
	typedef struct packed {
		logic [NUM_PINS-1:0] func;
		logic [NUM_PINS-1:0] cfg;
		logic [NUM_PINS-1:0] data;
		logic [NUM_PINS-1:0] afsel;
		logic [NUM_PINS-1:0] pout;
		logic [NUM_PINS-1:0] poe_n;
		logic [NUM_PART-1:0] prst_n;
		logic expint_n;
		logic [HP_NUM_IN-1:0][HP_GROUPS-1:0] hpi;
		logic awready;
		logic [ADDR_W-1:0] awaddr;
		logic wready;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gpm_st_t;

	gpm_st_t st_r, st_nxt;
	logic [NUM_PINS-1:0] smp; // synchronised, sampled pin levels

	// synchroniser and 128 ns sampler for every pin
	gpm_sync #(.W(NUM_PINS), .CYC(SAMPLE_CYC)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(pin_in),
		.dout(smp)
	);

	// merge one bus word into the low or high half of a field
	function automatic logic [53:0] wr_half(logic [53:0] r, logic hi,
		logic [31:0] d, logic [3:0] s);
		logic [63:0] t;
		logic [31:0] w;
		t = {10'h000, r};
		w = hi ? t[63:32] : t[31:0];
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				w[8*b +: 8] = d[8*b +: 8];
			end
		end
		if (hi) begin
			t[63:32] = w;
		end else begin
			t[31:0] = w;
		end
		return t[53:0];
	endfunction : wr_half

	// pick the low or high word of a field; unused bits read zero
	function automatic logic [31:0] rd_half(logic [53:0] r, logic hi);
		logic [63:0] t;
		t = {10'h000, r};
		return hi ? t[63:32] : t[31:0];
	endfunction : rd_half

	// alternate output of pin p: {drives, level}; no drive means input
	function automatic logic [1:0] alt_drive(int p, logic sel);
		int g;
		int k;
		alt_drive = 2'b00;
		g = (p - PIN_HP_BASE) / HP_GRP_PINS;
		k = (p - PIN_HP_BASE) % HP_GRP_PINS;
		if (!sel) begin
			if (p == PIN_GPE) begin
				alt_drive = {1'b1, hotplug_event_out};
			end else if (p >= PIN_HP_BASE) begin
				// hot-plug indicators, power enable, slot reset
				case (k)
					HP_AI: alt_drive = {1'b1, hp_attention_indicator_n[g]};
					HP_PI: alt_drive = {1'b1, hp_power_indicator_n[g]};
					HP_PE: alt_drive = {1'b1, hp_power_enable[g]};
					HP_RS: alt_drive = {1'b1, hp_slot_reset_n[g]};
					default: alt_drive = 2'b00;
				endcase
			end
		end else begin
			// link status, active low
			if (p == PIN_LINK0_UP) begin
				alt_drive = {1'b1, port_link_up_n[0]};
			end else if (p == PIN_LINK0_ACT) begin
				alt_drive = {1'b1, port_link_active_n[0]};
			end else if (p >= PIN_LINK_BASE && p <= PIN_LINK_LAST) begin
				if (p % 2 == 0) begin
					alt_drive = {1'b1,
						port_link_up_n[(p - LINK_PORT_OFS) / 2]};
				end else begin
					alt_drive = {1'b1,
						port_link_active_n[(p - LINK_PORT_OFS) / 2]};
				end
			end
		end
	endfunction : alt_drive

	// alternate input of pin p: sampled level when selected, else high
	function automatic logic alt_in(int p, logic sel);
		return (st_r.func[p] && st_r.afsel[p] == sel) ? smp[p] : 1'b1;
	endfunction : alt_in

	// next state: bus slave, pin drive and alternate inputs
	always_comb begin
		logic [1:0] drv;
		logic hi;
		int p;
		drv = 2'b00;
		hi = 1'b0;
		p = 0;
		st_nxt = st_r;
		// write address and data taken in either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.awaddr = s_axi_awaddr;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
			st_nxt.wready = 1'b0;
		end
		// both held: perform the write and answer
		if (!st_r.awready && !st_r.wready && !st_r.bvalid) begin
			hi = st_r.awaddr[2];
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.awaddr & REG_PAIR_MASK)
				REG_FUNC: st_nxt.func =
					wr_half(st_r.func, hi, st_r.wdata, st_r.wstrb);
				REG_CFG: st_nxt.cfg =
					wr_half(st_r.cfg, hi, st_r.wdata, st_r.wstrb);
				REG_DATA: st_nxt.data =
					wr_half(st_r.data, hi, st_r.wdata, st_r.wstrb);
				REG_AFSEL: st_nxt.afsel =
					wr_half(st_r.afsel, hi, st_r.wdata, st_r.wstrb);
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end
		// response accepted: reopen both write channels
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end
		// read: answer in the cycle after the address is taken
		if (s_axi_arvalid && st_r.arready) begin
			hi = s_axi_araddr[2];
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			case (s_axi_araddr & REG_PAIR_MASK)
				REG_FUNC: st_nxt.rdata = rd_half(st_r.func, hi);
				REG_CFG: st_nxt.rdata = rd_half(st_r.cfg, hi);
				REG_DATA: st_nxt.rdata = rd_half(smp, hi);
				REG_AFSEL: st_nxt.rdata = rd_half(st_r.afsel, hi);
				default: begin
					st_nxt.rdata = 32'h00000000;
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
		// per-pin mode decode and drive
		for (p = 0; p < NUM_PINS; p++) begin
			if (!st_r.func[p]) begin
				st_nxt.poe_n[p] = !st_r.cfg[p];
				st_nxt.pout[p] = st_r.data[p];
			end else begin
				drv = alt_drive(p, st_r.afsel[p]);
				st_nxt.poe_n[p] = !drv[1];
				st_nxt.pout[p] = drv[0];
			end
		end
		// alternate inputs, high when no pin carries them
		for (p = 0; p < NUM_PART; p++) begin
			st_nxt.prst_n[p] = alt_in(p, 1'b0);
		end
		st_nxt.expint_n = alt_in(PIN_EXPINT, 1'b0);
		for (p = 0; p < HP_GROUPS * HP_NUM_IN; p++) begin
			st_nxt.hpi[p % HP_NUM_IN][p / HP_NUM_IN] = alt_in(PIN_HP_BASE
				+ (p / HP_NUM_IN) * HP_GRP_PINS + p % HP_NUM_IN,
				1'b0);
		end
	end

	// register the state; reset leaves every pin an input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.func <= FUNC_RST;
			st_r.cfg <= CFG_RST;
			st_r.data <= DATA_RST;
			st_r.afsel <= AFSEL_RST;
			st_r.poe_n <= '1;
			st_r.prst_n <= '1;
			st_r.expint_n <= 1'b1;
			st_r.hpi <= '1;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign pin_out = st_r.pout;
	assign pin_oe_n = st_r.poe_n;
	assign partition_reset_n = st_r.prst_n;
	assign expander_interrupt_n = st_r.expint_n;
	assign hp_attention_button_n = st_r.hpi[HP_AP];
	assign hp_presence_detect_n = st_r.hpi[HP_PD];
	assign hp_power_fault_n = st_r.hpi[HP_PF];
	assign hp_power_good_n = st_r.hpi[HP_PG];
	assign hp_retention_latch_n = st_r.hpi[HP_MRL];

	// checks
	AST_RESET_INPUT: assert property (@(posedge aclk)
		$rose(aresetn) |-> pin_oe_n == '1 && st_r.func == '0)
		else $error("pin driven right after reset");
	AST_GPO_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_r.func[0] && st_r.cfg[0] |=> !pin_oe_n[0]
		&& pin_out[0] == $past(st_r.data[0]))
		else $error("output pin not driving data latch");
	AST_GPI_FLOAT: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_r.func[1] && !st_r.cfg[1] |=> pin_oe_n[1])
		else $error("input pin driven");
	AST_DATA_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_DATA
		|=> s_axi_rvalid && s_axi_rdata == $past(smp[31:0]))
		else $error("data read not the sampled level");
	AST_PART_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_r.func[0] [*2] |-> partition_reset_n[0])
		else $error("unmapped partition reset not high");
	AST_PART_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[1] && !st_r.afsel[1] |=>
		partition_reset_n[1] == $past(smp[1]))
		else $error("partition reset not following pin");
	AST_GPE_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[PIN_GPE] && !st_r.afsel[PIN_GPE] |=> !pin_oe_n[PIN_GPE]
		&& pin_out[PIN_GPE] == $past(hotplug_event_out))
		else $error("event output not on its pin");
	AST_LINK_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[PIN_LINK0_UP] && st_r.afsel[PIN_LINK0_UP] |=>
		pin_out[PIN_LINK0_UP] == $past(port_link_up_n[0]))
		else $error("link up not on its pin");
	AST_ALT_IN_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[PIN_EXPINT] |=> pin_oe_n[PIN_EXPINT])
		else $error("alternate input pin driven");
	AST_HP_OUT_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[14] && !st_r.afsel[14] |=> !pin_oe_n[14])
		else $error("hot-plug indicator not driven");
	AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[0] |=> pin_oe_n[0])
		else $error("alternate input pin driven from latch");
	COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready);
	COV_GPO: cover property (@(posedge aclk) disable iff (!aresetn)
		!pin_oe_n[0]);
	COV_LINK: cover property (@(posedge aclk) disable iff (!aresetn)
		st_r.func[22] && st_r.afsel[22]);
endmodule : gpm_port

/* File: sim/gpm_board.sv */
// board-side model that drives released pins and reads back driven ones
`timescale 1ns/1ps
module gpm_board_model import gpm_pkg::*; (
	// device pin drivers
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe_n,
	// levels the board puts on released pins
	input wire logic [NUM_PINS-1:0] level,
	// resolved wire levels seen by the device
	output logic [NUM_PINS-1:0] pin_in
);
	// a driven pin carries the device level, a released one the board level
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_in[i] = pin_oe_n[i] ? level[i] : pin_out[i];
		end
	end
endmodule : gpm_board_model

/* File: sim/gpm_tb.sv */
// self-checking bench for the general purpose pin block
`timescale 1ns/1ps
module testbench import gpm_pkg::*;;
	logic aclk = 0; // core clock
	logic aresetn, awvalid, wvalid, bready, arvalid, rready, gev;
	logic awready, wready, bvalid, arready, rvalid, exp_int_n;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, prst_n;
	logic [3:0] wmask = 4'hF; // byte lanes of the next write
	logic [1:0] bresp, rresp, r;
	logic [53:0] pin_in, pin_out, pin_oe_n, brd, dat, fn, cf, af, t, v;
	logic [24:0] hpi; // button, presence, fault, good, latch
	logic [19:0] hpo; // attention, power ind, power enable, slot reset
	logic [15:0] lup, lact;
	logic [31:0] seed = 32'h6F3E58A9;
	int n_errors = 0;
	int checked = 0;

	// 125 MHz clock
	always #4 aclk = ~aclk;

	gpm_port i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.partition_reset_n(prst_n), .expander_interrupt_n(exp_int_n),
		.hp_attention_button_n(hpi[4:0]), .hp_presence_detect_n(hpi[9:5]),
		.hp_power_fault_n(hpi[14:10]), .hp_power_good_n(hpi[19:15]),
		.hp_retention_latch_n(hpi[24:20]), .hotplug_event_out(gev),
		.hp_attention_indicator_n(hpo[4:0]), .hp_power_indicator_n(hpo[9:5]),
		.hp_power_enable(hpo[14:10]), .hp_slot_reset_n(hpo[19:15]),
		.port_link_up_n(lup), .port_link_active_n(lact));

	gpm_board_model i_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.level(brd), .pin_in(pin_in));

	// one step of the random sequence
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr

	// 54 random bits
	task rnd54(output logic [53:0] o);
		seed = lfsr(seed);
		o[31:0] = seed;
		seed = lfsr(seed);
		o[53:32] = seed[21:0];
	endtask : rnd54

	// compare and count
	task chk(input string what, input logic [63:0] seen,
		input logic [63:0] want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : chk

	// verdict and end of run
	task summarize();
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// one bus write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= dv;
		wstrb <= wmask;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	// one bus read
	task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		dv = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// low word then high word of a 54-bit field
	task wr64(input logic [7:0] a, input logic [53:0] x);
		wr(a, x[31:0], r);
		chk("bresp", r, RESP_OKAY);
		wr(a + 8'h04, {10'h0, x[53:32]}, r);
		chk("bresp", r, RESP_OKAY);
	endtask : wr64

	task rd64(input logic [7:0] a, output logic [53:0] x);
		logic [31:0] lo;
		rd(a, lo, r);
		rd(a + 8'h04, d, r);
		chk("upper bits", d[31:22], 10'h0);
		x = {d[21:0], lo};
	endtask : rd64

	// expected {drives, level} of a pin in alternate mode
	function automatic logic [1:0] alt_exp(input int p, input logic a1);
		int k;
		k = (p - 9) % 9;
		if (!a1 && p == PIN_GPE) return {1'b1, gev};
		if (!a1 && p >= 9 && k >= HP_NUM_IN) return {1'b1, hpo[(k-5)*5+(p-9)/9]};
		if (a1 && (p == 4 || p == 5)) return {1'b1, p == 5 ? lact[0] : lup[0]};
		if (a1 && p >= 22 && p <= 51)
			return {1'b1, p[0] ? lact[(p-20)/2] : lup[(p-20)/2]};
		return 2'b00;
	endfunction : alt_exp

	// let sampling settle, then check every pin and alternate input
	task verify();
		logic [53:0] drv, val, rdv;
		logic [1:0] e;
		int q;
		repeat (40) @(posedge aclk);
		for (int p = 0; p < NUM_PINS; p++) begin
			e = fn[p] ? alt_exp(p, af[p]) : {cf[p], dat[p]};
			drv[p] = e[1];
			val[p] = e[0];
		end
		chk("pin_oe_n", pin_oe_n, 54'(~drv));
		chk("pin_out", pin_out & drv, val & drv);
		rd64(REG_DATA, rdv);
		chk("data", rdv, (val & drv) | (brd & ~drv));
		for (int i = 0; i < NUM_PART; i++)
			chk("partition", prst_n[i], !(fn[i] && !af[i]) || brd[i]);
		chk("expander", exp_int_n, !(fn[8] && !af[8]) || brd[8]);
		for (int i = 0; i < 25; i++) begin
			q = 9 + 9 * (i % 5) + i / 5;
			chk("hp input", hpi[i], !(fn[q] && !af[q]) || brd[q]);
		end
	endtask : verify

	// watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge aclk);
		n_errors++;
		summarize();
	end

	// main sequence
	initial begin
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready, gev} = '0;
		{awaddr, araddr, wdata, wstrb, hpo, lup, lact} = '0;
		{fn, cf, af, dat} = '0;
		rnd54(brd);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// reset leaves every pin a plain input
		rd64(REG_FUNC, v);
		chk("func", v, FUNC_RST);
		rd64(REG_CFG, v);
		chk("cfg", v, CFG_RST);
		rd64(REG_AFSEL, v);
		chk("afsel", v, AFSEL_RST);
		verify();
		// unmapped place answers with an error
		wr(8'h20, 32'hFFFFFFFF, r);
		chk("bresp", r, RESP_SLVERR);
		rd(8'h3C, d, r);
		chk("rresp", r, RESP_SLVERR);
		chk("rdata", d, 32'h0);
		// random output masks and data
		repeat (3) begin
			rnd54(cf);
			rnd54(dat);
			rnd54(t);
			brd <= t;
			wr64(REG_CFG, cf);
			wr64(REG_DATA, dat);
			// one partial write: only byte lanes 0 and 2 land
			rnd54(t);
			wmask = 4'h5;
			wr(REG_DATA, t[31:0], r);
			chk("bresp", r, RESP_OKAY);
			wmask = 4'hF;
			dat[7:0] = t[7:0];
			dat[23:16] = t[23:16];
			verify();
		end
		// all alternates 0, all alternates 1, then mixed
		for (int a = 0; a < 4; a++) begin
			rnd54(fn);
			rnd54(af);
			if (a < 2) fn = '1;
			if (a < 2) af = a[0] ? '1 : '0;
			rnd54(t);
			brd <= t;
			rnd54(t);
			{gev, hpo, lup, lact} <= t[52:0];
			wr64(REG_FUNC, fn);
			wr64(REG_AFSEL, af);
			verify();
		end
		// second reset in mid-run
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		{fn, cf, af, dat} = '0;
		verify();
		summarize();
	end
endmodule : testbench
